// file: src/lcfs_pkg.sv
// shared constants and types of the led channel fault supervisor
package lcfs_pkg;

	// ========================================
	// channel count and timing
	localparam int LCFS_NCH = 8;
	localparam int CLK_PERIOD_NS = 10;
	// pull-up settling before comparators are trusted
	localparam int SETTLE_NS = 20000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 12;

	// ========================================
	// register offsets
	localparam logic [7:0] ADDR_FAULT_LOW = 8'h38;
	localparam logic [7:0] ADDR_FAULT_HIGH = 8'h39;
	localparam logic [7:0] ADDR_REG_LATCH_LOW = 8'h3a;
	localparam logic [7:0] ADDR_REG_LATCH_HIGH = 8'h3b;
	localparam logic [7:0] ADDR_PIN_SHORTED = 8'h3c;
	localparam logic [7:0] ADDR_REG_STATUS = 8'h3d;
	localparam logic [7:0] ADDR_UNUSED_MAP = 8'h3e;

	// ========================================
	// fault bit positions in the 16-bit fault word (fault n at bit n-1)
	localparam int FAULT_OVP_BIT = 7;
	localparam int FAULT_PIN_GND_BIT = 10;

	// ========================================
	// reset values
	localparam logic [7:0] RST_CHAN = 8'h00;
	localparam logic [15:0] RST_FAULT = 16'h0000;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// ========================================
	// types
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_SETTLE = 6'b000010,
		ST_HOLD = 6'b000100,
		ST_RUN = 6'b001000,
		ST_RETEST = 6'b010000,
		ST_SHUTDOWN = 6'b100000
	} lcfs_state_e;

	// comparator results of each led_sink_pin
	typedef struct packed {
		logic [LCFS_NCH-1:0] below_short;  // level under 120 mV
		logic [LCFS_NCH-1:0] above_used;   // level over 270 mV
	} lcfs_sense_s;

endpackage

// file: src/lcfs_supervisor.sv
// led sink channel ground-short, unused and open-string supervisor
`timescale 1ns/1ps

// Function
// - first enable tests every pin before soft start
// - under 120 mV means shorted to ground
// - over 270 mV means used, unused if neither over 270 mV nor shorted
// - host-disabled and unused channels leave regulation
// - unused channels never request boost rise
// - any short at the first-enable test holds off soft start
// - enabled channel under target requests boost rise
// - regulation status bit set on overvoltage trip
// - overvoltage trip retests unregulated channels
// - retest short: latched shutdown, fault 11, shorted bit
// - retest open: drop channel, set latch bit
// - clear fault flag after open channel removal
// - startup overvoltage unregulated channel treated open
// - faults recorded in registers 0x38 and 0x39
module lcfs_supervisor
	import lcfs_pkg::*;
(
	input wire logic clock,                          // 100 MHz clock
	input wire logic rst,                            // async reset, high
	input wire logic clock_en,                       // freezes state when low
	input wire logic enable,                         // device enable level
	input wire lcfs_sense_s sense,                   // pin comparators
	input wire logic [LCFS_NCH-1:0] below_target,    // current under target
	input wire logic output_overvoltage_trip,        // overvoltage comparator
	input wire logic [LCFS_NCH-1:0] host_disable,    // host channel disables
	input wire logic status_clear,                   // host clear pulse
	input wire logic [7:0] reg_addr,                 // register read address
	output logic [7:0] reg_rdata,                    // register read data
	output logic [LCFS_NCH-1:0] pullup_en,           // pin pull-up sources
	output logic soft_start_go,                      // boost may run
	output logic boost_shutdown,                     // latched boost stop
	output logic [LCFS_NCH-1:0] regulate_mask,       // channels in the loop
	output logic [LCFS_NCH-1:0] raise_request,       // boost rise requests
	output logic fault_flag                          // fault indicator
);

	// ========================================
	// state
	lcfs_state_e state_ff;
	lcfs_state_e nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic checked_ff;
	logic enable_d_ff;
	logic [LCFS_NCH-1:0] unused_ff;
	logic [LCFS_NCH-1:0] removed_ff;
	logic [LCFS_NCH-1:0] retest_ff;
	logic [LCFS_NCH-1:0] shorted_ff;
	logic [LCFS_NCH-1:0] reg_latch_ff;
	logic [LCFS_NCH-1:0] reg_stat_ff;
	logic [15:0] fault_ff;
	logic flag_ff;
	logic [7:0] rdata_ff;

	logic [LCFS_NCH-1:0] nxt_unused;
	logic [LCFS_NCH-1:0] nxt_removed;
	logic [LCFS_NCH-1:0] nxt_retest;
	logic [LCFS_NCH-1:0] nxt_shorted;
	logic [LCFS_NCH-1:0] nxt_reg_latch;
	logic [LCFS_NCH-1:0] nxt_reg_stat;
	logic [15:0] nxt_fault;
	logic nxt_flag;
	logic [7:0] nxt_rdata;

	// ========================================
	// decoding
	wire logic enable_rise = enable & ~enable_d_ff;
	wire logic settled = (cnt_ff == CNT_W'(SETTLE_CYC - 1));
	wire logic [LCFS_NCH-1:0] short_now = sense.below_short;
	wire logic [LCFS_NCH-1:0] used_now = sense.above_used;
	wire logic any_short = |short_now;
	wire logic [LCFS_NCH-1:0] active =
		~unused_ff & ~host_disable & ~removed_ff;
	wire logic [LCFS_NCH-1:0] unregulated = active & below_target;
	wire logic in_run = (state_ff == ST_RUN);
	wire logic ovp_event = in_run & output_overvoltage_trip;
	wire logic [LCFS_NCH-1:0] retest_short = retest_ff & short_now;
	wire logic retest_found = |retest_short;
	wire logic retest_done = (state_ff == ST_RETEST) & settled;

	// ========================================
	// outputs
	assign regulate_mask = in_run ? active : RST_CHAN;
	// unused and removed channels drop out through active
	assign raise_request = in_run ? unregulated : RST_CHAN;
	assign soft_start_go = in_run;
	assign boost_shutdown = (state_ff == ST_SHUTDOWN);
	assign fault_flag = flag_ff;
	assign reg_rdata = rdata_ff;

	always_comb begin
		case (state_ff)
			ST_SETTLE, ST_HOLD: pullup_en = {LCFS_NCH{1'b1}};
			ST_RETEST: pullup_en = retest_ff;
			default: pullup_en = RST_CHAN;
		endcase
	end

	// ========================================
	// sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_cnt = '0;
				if (enable_rise && !checked_ff) begin
					nxt_state = ST_SETTLE;
				end else if (enable_rise) begin
					nxt_state = ST_RUN;
				end
			end
			ST_SETTLE: begin
				nxt_cnt = cnt_ff + CNT_W'(1);
				if (settled) begin
					nxt_cnt = '0;
					nxt_state = any_short ? ST_HOLD : ST_RUN;
				end
			end
			ST_HOLD: begin
				if (!any_short) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				nxt_cnt = '0;
				if (ovp_event) begin
					nxt_state = ST_RETEST;
				end
			end
			ST_RETEST: begin
				nxt_cnt = cnt_ff + CNT_W'(1);
				if (settled) begin
					nxt_cnt = '0;
					nxt_state = retest_found ? ST_SHUTDOWN : ST_RUN;
				end
			end
			ST_SHUTDOWN: begin
				nxt_state = ST_SHUTDOWN;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = '0;
			end
		endcase
		if (!enable && state_ff != ST_SHUTDOWN) begin
			nxt_state = ST_IDLE;
			nxt_cnt = '0;
		end
	end

	// ========================================
	// channel bookkeeping
	always_comb begin
		nxt_unused = unused_ff;
		nxt_removed = removed_ff;
		nxt_retest = retest_ff;
		if (state_ff == ST_SETTLE && settled) begin
			nxt_unused = ~used_now & ~short_now;
		end
		if (ovp_event) begin
			// startup and run trips take the same path
			nxt_retest = unregulated;
		end
		if (retest_done && !retest_found) begin
			nxt_removed = removed_ff | retest_ff;
		end
		if (enable_rise) begin
			nxt_removed = RST_CHAN;
		end
	end

	// sticky status, a set in the clearing cycle wins
	wire logic wipe = status_clear | enable_rise;
	wire logic [LCFS_NCH-1:0] set_short =
		retest_done ? retest_short : RST_CHAN;
	wire logic [LCFS_NCH-1:0] set_open =
		(retest_done && !retest_found) ? retest_ff : RST_CHAN;

	always_comb begin
		nxt_shorted = (wipe ? RST_CHAN : shorted_ff) | set_short;
		nxt_reg_latch = (wipe ? RST_CHAN : reg_latch_ff) | set_open;
		// live status: 0 while regulating or disabled, 1 after a trip
		nxt_reg_stat = (reg_stat_ff & unregulated) |
			(ovp_event ? unregulated : RST_CHAN);
	end

	// ========================================
	// fault record and indicator
	always_comb begin
		nxt_fault = wipe ? RST_FAULT : fault_ff;
		nxt_flag = flag_ff;
		if (ovp_event) begin
			nxt_fault[FAULT_OVP_BIT] = 1'b1;
			nxt_flag = 1'b1;
		end
		if (retest_done && retest_found) begin
			nxt_fault[FAULT_PIN_GND_BIT] = 1'b1;
			nxt_flag = 1'b1;
		end else if (retest_done) begin
			nxt_flag = 1'b0;
		end
		// a ground-short set in the clearing cycle wins over the clear
		if (status_clear && state_ff != ST_SHUTDOWN && !ovp_event &&
			!(retest_done && retest_found)) begin
			nxt_flag = 1'b0;
		end
	end

	// ========================================
	// register read
	always_comb begin
		case (reg_addr)
			ADDR_FAULT_LOW: nxt_rdata = fault_ff[7:0];
			ADDR_FAULT_HIGH: nxt_rdata = fault_ff[15:8];
			ADDR_REG_LATCH_LOW: nxt_rdata = reg_latch_ff;
			ADDR_REG_LATCH_HIGH: nxt_rdata = RST_RDATA;
			ADDR_PIN_SHORTED: nxt_rdata = shorted_ff;
			ADDR_REG_STATUS: nxt_rdata = reg_stat_ff;
			ADDR_UNUSED_MAP: nxt_rdata = unused_ff;
			default: nxt_rdata = RST_RDATA;
		endcase
	end

	// ========================================
	// flip-flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			checked_ff <= 1'b0;
			enable_d_ff <= 1'b0;
		end else if (clock_en) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			checked_ff <= checked_ff | (nxt_state == ST_RUN);
			enable_d_ff <= enable;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			unused_ff <= RST_CHAN;
			removed_ff <= RST_CHAN;
			retest_ff <= RST_CHAN;
			shorted_ff <= RST_CHAN;
			reg_latch_ff <= RST_CHAN;
			reg_stat_ff <= RST_CHAN;
		end else if (clock_en) begin
			unused_ff <= nxt_unused;
			removed_ff <= nxt_removed;
			retest_ff <= nxt_retest;
			shorted_ff <= nxt_shorted;
			reg_latch_ff <= nxt_reg_latch;
			reg_stat_ff <= nxt_reg_stat;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			fault_ff <= RST_FAULT;
			flag_ff <= 1'b0;
			rdata_ff <= RST_RDATA;
		end else if (clock_en) begin
			fault_ff <= nxt_fault;
			flag_ff <= nxt_flag;
			rdata_ff <= nxt_rdata;
		end
	end

endmodule

// file: tb/lcfs_supervisor_asserts.sv
// port-level checks of the led channel fault supervisor
`timescale 1ns/1ps
module lcfs_supervisor_asserts
	import lcfs_pkg::*;
(
	input wire logic clock, // clock
	input wire logic rst, // reset
	input wire logic clock_en, // advance
	input wire logic enable, // enable
	input wire lcfs_sense_s sense, // comparators
	input wire logic [LCFS_NCH-1:0] below_target, // under target
	input wire logic output_overvoltage_trip, // ovp
	input wire logic [LCFS_NCH-1:0] host_disable, // disables
	input wire logic status_clear, // clear
	input wire logic [7:0] reg_addr, // address
	input wire logic [7:0] reg_rdata, // read data
	input wire logic [LCFS_NCH-1:0] pullup_en, // pull-ups
	input wire logic soft_start_go, // run
	input wire logic boost_shutdown, // stop
	input wire logic [LCFS_NCH-1:0] regulate_mask, // loop set
	input wire logic [LCFS_NCH-1:0] raise_request, // raise
	input wire logic fault_flag // flag
);
	// ========================================
	// pull-up age counter
	logic [CNT_W:0] pu_cnt_ff;
	logic [CNT_W:0] nxt_pu_cnt;
	assign nxt_pu_cnt = (pullup_en != 8'h00) ? pu_cnt_ff + 1'b1 : '0;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pu_cnt_ff <= '0;
		end else if (clock_en) begin
			pu_cnt_ff <= nxt_pu_cnt;
		end
	end
	// ========================================
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_ovp_in_run;
		clock_en && soft_start_go && output_overvoltage_trip;
	endsequence
	sequence s_retest;
		fault_flag && !soft_start_go && pullup_en == $past(raise_request);
	endsequence
	chk_ovp_retest: assert property (s_ovp_in_run |=> s_retest)
		else $error("overvoltage did not start retest");
	chk_disabled_out: assert property ((regulate_mask & host_disable) == 8'h00)
		else $error("disabled channel in loop");
	chk_unused_quiet: assert property ((raise_request & ~regulate_mask) == 8'h00)
		else $error("channel outside loop asks for raise");
	chk_raise_match: assert property (soft_start_go |->
		raise_request == (regulate_mask & below_target))
		else $error("raise request mismatch");
	chk_short_hold: assert property (pullup_en == 8'hff &&
		sense.below_short != 8'h00 |=> !soft_start_go)
		else $error("started with a grounded pin");
	chk_shutdown_latch: assert property (boost_shutdown |=>
		boost_shutdown && fault_flag && !soft_start_go)
		else $error("shutdown not held");
	chk_settle_time: assert property ($rose(soft_start_go) &&
		$past(pullup_en) == 8'hff |-> $past(pu_cnt_ff) >= SETTLE_CYC - 1)
		else $error("started before pull-ups settled");
	chk_open_clears: assert property (soft_start_go &&
		$past(pullup_en) != 8'h00 && $past(pullup_en) != 8'hff |-> !fault_flag)
		else $error("flag left after open removal");
	chk_high_zero: assert property (clock_en &&
		reg_addr == ADDR_REG_LATCH_HIGH |=> reg_rdata == 8'h00)
		else $error("upper latch not zero");
endmodule
bind lcfs_supervisor lcfs_supervisor_asserts u_chk (.clock(clock), .rst(rst),
	.clock_en(clock_en), .enable(enable), .sense(sense),
	.below_target(below_target), .host_disable(host_disable),
	.output_overvoltage_trip(output_overvoltage_trip),
	.status_clear(status_clear), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.pullup_en(pullup_en), .soft_start_go(soft_start_go),
	.boost_shutdown(boost_shutdown), .regulate_mask(regulate_mask),
	.raise_request(raise_request), .fault_flag(fault_flag));

// file: tb/lcfs_led_model.sv
// behavioural led strings and boost output stage
`timescale 1ns/1ps
module lcfs_led_model
	import lcfs_pkg::*;
#(
	parameter int RAMP = 20
)(
	input wire logic clock, // clock
	input wire logic [LCFS_NCH-1:0] pullup_en, // pull-ups
	input wire logic [LCFS_NCH-1:0] raise_request, // raise
	input wire logic [LCFS_NCH-1:0] used, // string fitted
	input wire logic [LCFS_NCH-1:0] shorted, // pin grounded
	input wire logic [LCFS_NCH-1:0] open_str, // string broken
	output lcfs_sense_s sense, // comparators
	output logic [LCFS_NCH-1:0] below_target, // under target
	output logic output_overvoltage_trip // ovp
);
	int ramp_cnt = 0;
	// a grounded pin reads low whatever the pull-up
	assign sense = {shorted, pullup_en & used & ~shorted};
	assign below_target = ~(used & ~open_str & ~shorted);
	// boost climbs while anyone asks, then trips
	always @(negedge clock) begin
		ramp_cnt <= (|raise_request) ? ramp_cnt + 1 : 0;
		output_overvoltage_trip <= (|raise_request) && ramp_cnt >= RAMP;
	end
endmodule

// file: tb/testbench.sv
// self-checking bench for the led channel fault supervisor
`timescale 1ns/1ps
module testbench;
	import lcfs_pkg::*;
	logic clock = 0, rst = 1, clock_en = 1, enable = 0, status_clear = 0;
	logic [7:0] host_disable = 8'h02, reg_addr = 8'h00, reg_rdata;
	logic [7:0] used = 8'h7f, shorted = 8'h08, open_str = 8'h04;
	logic [7:0] pullup_en, regulate_mask, raise_request, below_target;
	logic soft_start_go, boost_shutdown, fault_flag, output_overvoltage_trip;
	lcfs_sense_s sense;
	int miscompares = 0, samples_checked = 0;
	lcfs_supervisor dut (.clock(clock), .rst(rst), .clock_en(clock_en),
		.enable(enable), .sense(sense), .below_target(below_target),
		.output_overvoltage_trip(output_overvoltage_trip),
		.host_disable(host_disable), .status_clear(status_clear),
		.reg_addr(reg_addr), .reg_rdata(reg_rdata), .pullup_en(pullup_en),
		.soft_start_go(soft_start_go), .boost_shutdown(boost_shutdown),
		.regulate_mask(regulate_mask), .raise_request(raise_request),
		.fault_flag(fault_flag));
	lcfs_led_model strings (.clock(clock), .pullup_en(pullup_en),
		.raise_request(raise_request), .used(used), .shorted(shorted),
		.open_str(open_str), .sense(sense), .below_target(below_target),
		.output_overvoltage_trip(output_overvoltage_trip));
	initial begin
		forever #5 clock = ~clock;
	end
	// ========================================
	// tasks
	task automatic check(input string what, input logic [7:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(input logic [7:0] a, exp, input string what);
		@(negedge clock);
		reg_addr = a;
		@(negedge clock);
		check(what, reg_rdata, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic finish_test;
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		finish_test;
	end
	// ========================================
	// tests
	initial begin
		cyc(4);
		check("reset outs", pullup_en | regulate_mask | reg_rdata, 8'h00);
		rst = 0;
		enable = 1;
		cyc(2);
		check("settle pullups", pullup_en, 8'hff);
		cyc(SETTLE_CYC + 10);
		check("held start", {7'h00, soft_start_go}, 8'h00);
		shorted = 8'h00;
		cyc(1);
		check("run mask", regulate_mask, 8'h7d);
		check("raise", raise_request, 8'h04);
		cyc(25);
		check("retest pins", pullup_en, 8'h04);
		check("ovp flag", {7'h00, fault_flag}, 8'h01);
		rd(ADDR_FAULT_LOW, 8'h80, "fault low");
		rd(ADDR_REG_STATUS, 8'h04, "reg status");
		cyc(SETTLE_CYC);
		check("open dropped", regulate_mask, 8'h79);
		check("flag cleared", {7'h00, fault_flag}, 8'h00);
		rd(ADDR_REG_LATCH_LOW, 8'h04, "latch low");
		shorted = 8'h10;
		cyc(SETTLE_CYC + 40);
		check("shutdown", {6'h00, boost_shutdown, fault_flag}, 8'h03);
		rd(ADDR_FAULT_HIGH, 8'h04, "fault high");
		rd(ADDR_PIN_SHORTED, 8'h10, "shorted map");
		rd(ADDR_REG_LATCH_HIGH, 8'h00, "latch high");
		rd(8'h00, 8'h00, "unmapped");
		status_clear = 1;
		cyc(1);
		status_clear = 0;
		rd(ADDR_PIN_SHORTED, 8'h00, "cleared map");
		// read data must hold while the clock enable is low
		clock_en = 0;
		rd(ADDR_UNUSED_MAP, 8'h00, "frozen read");
		clock_en = 1;
		rd(ADDR_UNUSED_MAP, 8'h80, "unused map");
		finish_test;
	end
endmodule
